// ===== hdl/instruction_cycle_timing.sv
// instruction cycle timing sequencer: runs save, address and operation steps and paces bus accesses
module instruction_cycle_timing #(
  parameter int EA_W = 8
) (
  // clock, reset and enable
  input  wire logic                      i_clk,
  input  wire logic                      i_rst_b,
  input  wire logic                      i_ce,
  // operation request
  input  wire logic                      i_start,
  input  wire cycle_timing_pkg::op_t     i_op,
  input  wire logic                      i_long_bus,
  input  wire logic [EA_W-1:0]           i_ea_clocks,
  input  wire logic [3:0]                i_operand_reads,
  input  wire logic                      i_write_fault,
  // bus activity
  output logic                           o_rd,
  output logic                           o_pf,
  output logic                           o_wr,
  output logic [3:0]                     o_reads,
  output logic [3:0]                     o_prefetches,
  output logic [3:0]                     o_writes,
  // progress and overlap
  output logic                           o_busy,
  output logic                           o_done,
  output cycle_timing_pkg::phase_t       o_phase,
  output logic [EA_W:0]                  o_elapsed,
  output logic signed [3:0]              o_head,
  output logic signed [3:0]              o_tail,
  output logic                           o_early_next
);
  import cycle_timing_pkg::*;

  // ==========================================================
  // elaboration checks
  // the elapsed counter needs room for the address time plus the longest step
  if (EA_W < 7 || EA_W > 16) begin : g_bad_ea_w
    $error("EA_W must lie between 7 and 16");
  end

  // ==========================================================
  // state
  op_t               op_q;
  op_time_t          rec_q;
  logic [EA_W-1:0]   ea_q;
  logic [EA_W:0]     cnt;
  logic              wflt_q;

  op_t               next_op;
  op_time_t          next_rec;
  op_time_t          rec;
  logic [EA_W-1:0]   next_ea;
  logic [EA_W:0]     next_cnt;
  logic              next_wflt;
  phase_t            next_phase;
  logic              next_rd;
  logic              next_pf;
  logic              next_wr;
  logic [3:0]        next_reads;
  logic [3:0]        next_prefetches;
  logic [3:0]        next_writes;
  logic              next_busy;
  logic              next_done;
  logic [EA_W:0]     next_elapsed;
  logic signed [3:0] next_head;
  logic signed [3:0] next_tail;
  logic              next_early;
  logic [4:0]        rp_end;
  logic [4:0]        rpw_end;

  // ==========================================================
  // next-state logic
  // accesses are issued one per clock from the start of the step, reads first, so they always
  // sit inside the step's total; no row has more accesses than clocks
  always_comb begin
    rec             = op_lookup(i_op);
    rp_end          = 5'(rec_q.rd) + 5'(rec_q.pf);
    rpw_end         = rp_end + 5'(rec_q.wr);
    next_op         = op_q;
    next_rec        = rec_q;
    next_ea         = ea_q;
    next_cnt        = cnt;
    next_wflt       = wflt_q;
    next_phase      = o_phase;
    next_rd         = 1'b0;
    next_pf         = 1'b0;
    next_wr         = 1'b0;
    next_reads      = o_reads;
    next_prefetches = o_prefetches;
    next_writes     = o_writes;
    next_busy       = o_busy;
    next_done       = 1'b0;
    next_elapsed    = (o_phase == PH_IDLE) ? o_elapsed : o_elapsed + 1'b1;
    next_head       = o_head;
    next_tail       = o_tail;
    next_early      = o_early_next;
    unique case (o_phase)
      PH_IDLE: begin
        if (i_start) begin
          // control steps stretch by two clocks on long operand transfers
          if (rec.ctl && i_long_bus) begin
            rec.total = rec.total + LONG_BUS_ADJ;
            rec.tail  = rec.tail + 4'(LONG_BUS_ADJ);
          end
          // the bounds pair check reads as many operands as the caller says
          if (i_op == OP_BOUNDS_PAIR_CHECK) begin
            rec.rd = i_operand_reads;
          end
          // a write that faulted is run once more by the return
          if (i_op == OP_RET_FAULT_INSTR && i_write_fault) begin
            rec.wr = 4'h1;
          end
          next_op         = i_op;
          next_rec        = rec;
          next_ea         = i_ea_clocks;
          next_wflt       = i_write_fault;
          next_cnt        = '0;
          next_reads      = 4'h0;
          next_prefetches = 4'h0;
          next_writes     = 4'h0;
          next_elapsed    = '0;
          next_busy       = 1'b1;
          next_head       = rec.head;
          next_tail       = rec.tail;
          next_early      = rec.tail < 0;
          if (rec.save) begin
            next_phase = PH_SAVE;
          end else if (i_ea_clocks != '0) begin
            next_phase = PH_EA;
          end else begin
            next_phase = PH_OPER;
          end
        end
      end
      PH_SAVE: begin
        // the save step spends one prefetch in its first clock
        next_pf  = (cnt == '0);
        next_cnt = cnt + 1'b1;
        if (cnt == (EA_W + 1)'(SAVE_CLOCKS - 4'h1)) begin
          next_cnt   = '0;
          next_phase = (ea_q != '0) ? PH_EA : PH_OPER;
        end
      end
      PH_EA: begin
        // fetch address time added ahead of the operation step
        next_cnt = cnt + 1'b1;
        if (next_cnt == {1'b0, ea_q}) begin
          next_cnt   = '0;
          next_phase = PH_OPER;
        end
      end
      PH_OPER: begin
        next_rd  = cnt < (EA_W + 1)'(rec_q.rd);
        next_pf  = !next_rd && cnt < (EA_W + 1)'(rp_end);
        next_wr  = !next_rd && !next_pf && cnt < (EA_W + 1)'(rpw_end);
        next_cnt = cnt + 1'b1;
        if (next_cnt == (EA_W + 1)'(rec_q.total)) begin
          next_cnt   = '0;
          next_phase = PH_IDLE;
          next_busy  = 1'b0;
          next_done  = 1'b1;
        end
      end
      default: begin
        // an illegal phase code falls back to idle
        next_phase = PH_IDLE;
        next_busy  = 1'b0;
        next_cnt   = '0;
      end
    endcase
    // running access tallies follow the pulses
    if (next_rd) begin
      next_reads = o_reads + 4'h1;
    end
    if (next_pf) begin
      next_prefetches = o_prefetches + 4'h1;
    end
    if (next_wr) begin
      next_writes = o_writes + 4'h1;
    end
  end

  // ==========================================================
  // registers; everything freezes while the enable is low
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      op_q         <= OP_NOP;
      rec_q        <= '0;
      ea_q         <= '0;
      cnt          <= '0;
      wflt_q       <= 1'b0;
      o_phase      <= PH_IDLE;
      o_rd         <= 1'b0;
      o_pf         <= 1'b0;
      o_wr         <= 1'b0;
      o_reads      <= 4'h0;
      o_prefetches <= 4'h0;
      o_writes     <= 4'h0;
      o_busy       <= 1'b0;
      o_done       <= 1'b0;
      o_elapsed    <= '0;
      o_head       <= 4'sh0;
      o_tail       <= 4'sh0;
      o_early_next <= 1'b0;
    end else if (i_ce) begin
      op_q         <= next_op;
      rec_q        <= next_rec;
      ea_q         <= next_ea;
      cnt          <= next_cnt;
      wflt_q       <= next_wflt;
      o_phase      <= next_phase;
      o_rd         <= next_rd;
      o_pf         <= next_pf;
      o_wr         <= next_wr;
      o_reads      <= next_reads;
      o_prefetches <= next_prefetches;
      o_writes     <= next_writes;
      o_busy       <= next_busy;
      o_done       <= next_done;
      o_elapsed    <= next_elapsed;
      o_head       <= next_head;
      o_tail       <= next_tail;
      o_early_next <= next_early;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  sequence s_bounds_start;
    o_phase == PH_IDLE && i_ce && i_start && i_op == OP_BOUNDS_PAIR_CHECK;
  endsequence
  sequence s_save_step;
    (o_phase == PH_SAVE)[*3] ##1 (o_phase != PH_SAVE);
  endsequence

  property p_one_access;
    $onehot0({o_rd, o_pf, o_wr});
  endproperty
  a_one_access: assert property (p_one_access) else $error("two bus accesses in one clock");

  property p_long_ctl;
    (o_phase == PH_IDLE && i_ce && i_start && i_long_bus && i_op == OP_SUBR_CALL) |=> o_tail == 4'sh0;
  endproperty
  a_long_ctl: assert property (p_long_ctl) else $error("long bus tail not stretched");

  property p_inside_total;
    o_done |-> (int'(o_reads) + int'(o_prefetches) + int'(o_writes)) <= int'(o_elapsed);
  endproperty
  a_inside_total: assert property (p_inside_total) else $error("accesses exceed clock count");

  property p_interrupt;
    o_done && op_q == OP_INTERRUPT |-> o_elapsed == 30 + ea_q && o_reads == 3 && o_prefetches == 2 && o_writes == 4;
  endproperty
  a_interrupt: assert property (p_interrupt) else $error("interrupt timing wrong");

  property p_bounds_save;
    disable iff (!i_rst_b || !i_ce) s_bounds_start |=> s_save_step;
  endproperty
  a_bounds_save: assert property (p_bounds_save) else $error("bounds check save step wrong");

  property p_fline_mem;
    o_done && op_q == OP_FLINE_SECOND_MEM |-> o_elapsed == 32 + ea_q && o_prefetches == 3 && o_writes == 4;
  endproperty
  a_fline_mem: assert property (p_fline_mem) else $error("memory trap timing wrong");

  property p_fline_reg;
    o_done && op_q == OP_FLINE_SECOND_REG |-> o_elapsed == 31 + ea_q && o_prefetches == 3 && o_reads == 2;
  endproperty
  a_fline_reg: assert property (p_fline_reg) else $error("register trap timing wrong");

  property p_fline_first;
    o_done && op_q == OP_FLINE_FIRST |-> o_elapsed == 25 + ea_q && o_writes == 4;
  endproperty
  a_fline_first: assert property (p_fline_first) else $error("first word trap timing wrong");

  property p_ret_rerun;
    o_done && op_q == OP_RET_FAULT_INSTR |-> o_elapsed == 50 + ea_q && o_writes == 4'(wflt_q);
  endproperty
  a_ret_rerun: assert property (p_ret_rerun) else $error("faulted write not rerun");

  property p_ret_four;
    o_done && op_q == OP_RET_FAULT_FOUR |-> o_elapsed == 66 + ea_q && o_reads == 10;
  endproperty
  a_ret_four: assert property (p_ret_four) else $error("four-word return timing wrong");

  property p_ret_six;
    o_done && op_q == OP_RET_FAULT_SIX |-> o_elapsed == 70 + ea_q && o_writes == 6;
  endproperty
  a_ret_six: assert property (p_ret_six) else $error("six-word return timing wrong");

  property p_fault_max;
    o_done && op_q == OP_FAULT_INSTR |-> o_elapsed <= 58 + ea_q;
  endproperty
  a_fault_max: assert property (p_fault_max) else $error("bus fault too slow");

  property p_bit_imm;
    o_done && op_q == OP_BIT_MOD_IMM_REG |-> o_elapsed == 6 + ea_q;
  endproperty
  a_bit_imm: assert property (p_bit_imm) else $error("immediate bit op timing wrong");

  property p_early;
    o_busy |-> o_early_next == (o_tail < 0);
  endproperty
  a_early: assert property (p_early) else $error("early start flag wrong");

endmodule : instruction_cycle_timing

// ===== hdl/cycle_timing_pkg.sv
// package: operation codes, phase codes and cycle tables for the timing sequencer
package cycle_timing_pkg;

  // ==========================================================
  // timing constants
  localparam int           CLK_PERIOD_NS   = 5;
  localparam int           BUS_CYCLE_NS    = 10;
  localparam int           BUS_CLOCKS      = (BUS_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int           IACK_MIN_CLOCKS = 3;
  localparam logic [3:0]   SAVE_CLOCKS     = 4'h3;
  localparam logic [7:0]   LONG_BUS_ADJ    = 8'h02;

  // ==========================================================
  // operations; bit_invert_op, bit_clear_op and bit_set_op share the bit_mod rows
  typedef enum logic [5:0] {
    OP_BIT_MOD_IMM_REG, OP_BIT_MOD_REG_REG, OP_BIT_MOD_IMM_MEM, OP_BIT_MOD_REG_MEM,
    OP_BIT_TEST_IMM_REG, OP_BIT_TEST_REG_REG, OP_BIT_TEST_IMM_MEM, OP_BIT_TEST_REG_MEM,
    OP_BRANCH_TAKEN, OP_BRANCH_B_NOT, OP_BRANCH_W_NOT, OP_BRANCH_L_NOT,
    OP_DEC_BRANCH_TRUE, OP_DEC_BRANCH_EXPIRED, OP_DEC_BRANCH_TAKEN,
    OP_SUBR_CALL, OP_SUBR_RETURN, OP_NOP, OP_BOUNDS_PAIR_CHECK,
    OP_INTERRUPT, OP_LOW_POWER_HALT, OP_BREAKPOINT_ACK, OP_COND_TRAP, OP_COND_NO_TRAP,
    OP_FLINE_FIRST, OP_FLINE_SECOND_REG, OP_FLINE_SECOND_MEM,
    OP_FAULT_INSTR, OP_FAULT_EXC, OP_RET_FOUR, OP_RET_SIX,
    OP_RET_FAULT_INSTR, OP_RET_FAULT_FOUR, OP_RET_FAULT_SIX
  } op_t;

  // sequencer phases, one-hot
  typedef enum logic [3:0] {
    PH_IDLE = 4'h1,
    PH_SAVE = 4'h2,
    PH_EA   = 4'h4,
    PH_OPER = 4'h8
  } phase_t;

  // one row of the cycle table
  typedef struct packed {
    logic [7:0]        total;
    logic [3:0]        rd;
    logic [3:0]        pf;
    logic [3:0]        wr;
    logic signed [3:0] head;
    logic signed [3:0] tail;
    logic              save;
    logic              ctl;
  } op_time_t;

  function automatic op_time_t mk(int t, int r, int p, int w, int h, int tl, int s, int c);
    mk = '{8'(t), 4'(r), 4'(p), 4'(w), 4'(h), 4'(tl), 1'(s), 1'(c)};
  endfunction : mk

  // total(r/p/w), head, tail, save step, control class
  function automatic op_time_t op_lookup(op_t op);
    op_lookup = mk(2, 0, 1, 0, 0, 0, 0, 0);
    unique case (op)
      OP_BIT_MOD_IMM_REG:    op_lookup = mk(6, 0, 2, 0, 2, 0, 0, 0);
      OP_BIT_MOD_REG_REG:    op_lookup = mk(6, 0, 1, 0, 4, 0, 0, 0);
      OP_BIT_MOD_IMM_MEM:    op_lookup = mk(8, 0, 2, 1, 1, 2, 0, 0);
      OP_BIT_MOD_REG_MEM:    op_lookup = mk(8, 0, 1, 1, 2, 2, 0, 0);
      OP_BIT_TEST_IMM_REG:   op_lookup = mk(4, 0, 2, 0, 2, 0, 0, 0);
      OP_BIT_TEST_REG_REG:   op_lookup = mk(4, 0, 1, 0, 2, 0, 0, 0);
      OP_BIT_TEST_IMM_MEM:   op_lookup = mk(4, 0, 2, 0, 1, 0, 0, 0);
      OP_BIT_TEST_REG_MEM:   op_lookup = mk(8, 0, 1, 0, 2, 0, 0, 0);
      OP_BRANCH_TAKEN:       op_lookup = mk(8, 0, 2, 0, 2, -2, 0, 0);
      OP_BRANCH_B_NOT:       op_lookup = mk(4, 0, 1, 0, 2, 0, 0, 0);
      OP_BRANCH_W_NOT:       op_lookup = mk(4, 0, 2, 0, 0, 0, 0, 0);
      OP_BRANCH_L_NOT:       op_lookup = mk(6, 0, 3, 1, 0, 0, 0, 0);
      OP_DEC_BRANCH_TRUE:    op_lookup = mk(4, 0, 2, 0, 1, 1, 0, 0);
      OP_DEC_BRANCH_EXPIRED: op_lookup = mk(6, 0, 2, 0, 2, 0, 0, 0);
      OP_DEC_BRANCH_TAKEN:   op_lookup = mk(10, 0, 2, 0, 6, -2, 0, 0);
      OP_SUBR_CALL:          op_lookup = mk(13, 0, 2, 2, 3, -2, 0, 1);
      OP_SUBR_RETURN:        op_lookup = mk(12, 2, 2, 0, 1, -2, 0, 1);
      OP_NOP:                op_lookup = mk(2, 0, 1, 0, 0, 0, 0, 1);
      OP_BOUNDS_PAIR_CHECK:  op_lookup = mk(18, 0, 0, 0, 2, 0, 1, 1);
      OP_INTERRUPT:          op_lookup = mk(30, 3, 2, 4, 0, -2, 0, 0);
      OP_LOW_POWER_HALT:     op_lookup = mk(25, 0, 3, 1, 3, -2, 0, 0);
      OP_BREAKPOINT_ACK:     op_lookup = mk(14, 1, 0, 0, 0, 0, 0, 0);
      OP_COND_TRAP:          op_lookup = mk(38, 2, 2, 6, 2, -2, 0, 0);
      OP_COND_NO_TRAP:       op_lookup = mk(4, 0, 1, 0, 2, 0, 0, 0);
      OP_FLINE_FIRST:        op_lookup = mk(25, 2, 2, 4, 0, -2, 0, 0);
      OP_FLINE_SECOND_REG:   op_lookup = mk(31, 2, 3, 4, 1, -2, 0, 0);
      OP_FLINE_SECOND_MEM:   op_lookup = mk(29, 2, 2, 4, 4, -2, 1, 0);
      OP_FAULT_INSTR:        op_lookup = mk(58, 2, 2, 12, 0, -2, 0, 0);
      OP_FAULT_EXC:          op_lookup = mk(48, 2, 2, 12, 0, -2, 0, 0);
      OP_RET_FOUR:           op_lookup = mk(24, 4, 2, 0, 1, -2, 0, 0);
      OP_RET_SIX:            op_lookup = mk(26, 4, 2, 0, 1, -2, 0, 0);
      OP_RET_FAULT_INSTR:    op_lookup = mk(50, 12, 12, 0, 1, -2, 0, 0);
      OP_RET_FAULT_FOUR:     op_lookup = mk(66, 10, 2, 4, 1, -2, 0, 0);
      OP_RET_FAULT_SIX:      op_lookup = mk(70, 12, 2, 6, 1, -2, 0, 0);
      default:               op_lookup = mk(2, 0, 1, 0, 0, 0, 0, 0);
    endcase
  endfunction : op_lookup

endpackage : cycle_timing_pkg

// ===== tb/bus_partner.sv
// bus partner model: memory and peripherals that take every access slot of the sequencer
module bus_partner (
  // clock, reset and enable
  input  wire logic i_clk,
  input  wire logic i_rst_b,
  input  wire logic i_ce,
  // access slots from the sequencer
  input  wire logic i_rd,
  input  wire logic i_pf,
  input  wire logic i_wr,
  // tallies for the bench
  output int        o_rd_count,
  output int        o_pf_count,
  output int        o_wr_count,
  output int        o_clash
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // slot acceptance
  // no wait states: each slot ends in the clock it is offered, so the sequencer counts hold as tabled
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rd_count <= 0;
      o_pf_count <= 0;
      o_wr_count <= 0;
      o_clash    <= 0;
    end else if (i_ce) begin
      // a slot held over enable gaps is one access, taken at the next enabled edge only
      o_rd_count <= o_rd_count + int'(i_rd);
      o_pf_count <= o_pf_count + int'(i_pf);
      o_wr_count <= o_wr_count + int'(i_wr);
      // one bus, so two slots in one cycle would be a collision
      if (int'(i_rd) + int'(i_pf) + int'(i_wr) > 1) begin
        o_clash <= o_clash + 1;
      end
    end
  end
endmodule : bus_partner

// ===== tb/tb_instruction_cycle_timing.sv
// testbench: times operations on the sequencer and compares with a reference count model
module tb_instruction_cycle_timing;
  timeunit 1ns;
  timeprecision 1ps;
  import cycle_timing_pkg::*;

  typedef int row_t [8];

  logic              i_clk, i_rst_b, i_ce, i_start, i_long_bus, i_write_fault;
  op_t               i_op;
  logic [7:0]        i_ea_clocks;
  logic [3:0]        i_operand_reads;
  logic              o_rd, o_pf, o_wr, o_busy, o_done, o_early_next;
  logic [3:0]        o_reads, o_prefetches, o_writes;
  phase_t            o_phase;
  logic [8:0]        o_elapsed;
  logic signed [3:0] o_head, o_tail;
  int                rd_count, pf_count, wr_count, clash, err_count, cmp_count;
  op_t               sweep[$] = '{OP_INTERRUPT, OP_BOUNDS_PAIR_CHECK, OP_SUBR_CALL, OP_RET_FAULT_INSTR, OP_NOP,
                                  OP_SUBR_RETURN, OP_LOW_POWER_HALT, OP_BREAKPOINT_ACK, OP_COND_TRAP,
                                  OP_FAULT_EXC, OP_RET_FOUR, OP_RET_SIX};

  instruction_cycle_timing #(.EA_W(8)) dut (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_ce(i_ce), .i_start(i_start), .i_op(i_op),
    .i_long_bus(i_long_bus), .i_ea_clocks(i_ea_clocks), .i_operand_reads(i_operand_reads),
    .i_write_fault(i_write_fault), .o_rd(o_rd), .o_pf(o_pf), .o_wr(o_wr), .o_reads(o_reads),
    .o_prefetches(o_prefetches), .o_writes(o_writes), .o_busy(o_busy), .o_done(o_done),
    .o_phase(o_phase), .o_elapsed(o_elapsed), .o_head(o_head), .o_tail(o_tail),
    .o_early_next(o_early_next));

  bus_partner u_bus (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_ce(i_ce), .i_rd(o_rd), .i_pf(o_pf), .i_wr(o_wr),
    .o_rd_count(rd_count), .o_pf_count(pf_count), .o_wr_count(wr_count), .o_clash(clash));

  // ==========================================================
  // clock and watchdog
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  // the whole run is some 1500 cycles; 20000 cycles means a hang
  initial begin
    #100000;
    err_count++;
    results();
  end

  // ==========================================================
  // reference model: total, reads, prefetches, writes, head, tail, save step, control class
  function automatic row_t exp_row(op_t op);
    row_t r;
    case (op)
      OP_SUBR_CALL:         r = '{13, 0, 2, 2, 3, -2, 0, 1};
      OP_BOUNDS_PAIR_CHECK: r = '{18, 0, 0, 0, 2, 0, 1, 1};
      OP_INTERRUPT:         r = '{30, 3, 2, 4, 0, -2, 0, 0};
      OP_FLINE_FIRST:       r = '{25, 2, 2, 4, 0, -2, 0, 0};
      OP_FLINE_SECOND_REG:  r = '{31, 2, 3, 4, 1, -2, 0, 0};
      OP_FLINE_SECOND_MEM:  r = '{29, 2, 2, 4, 4, -2, 1, 0};
      OP_FAULT_INSTR:       r = '{58, 2, 2, 12, 0, -2, 0, 0};
      OP_RET_FAULT_INSTR:   r = '{50, 12, 12, 0, 1, -2, 0, 0};
      OP_RET_FAULT_FOUR:    r = '{66, 10, 2, 4, 1, -2, 0, 0};
      OP_RET_FAULT_SIX:     r = '{70, 12, 2, 6, 1, -2, 0, 0};
      OP_BIT_MOD_IMM_REG:   r = '{6, 0, 2, 0, 2, 0, 0, 0};
      OP_BIT_TEST_IMM_MEM:  r = '{4, 0, 2, 0, 1, 0, 0, 0};
      OP_BRANCH_TAKEN:      r = '{8, 0, 2, 0, 2, -2, 0, 0};
      OP_DEC_BRANCH_TRUE:   r = '{4, 0, 2, 0, 1, 1, 0, 0};
      OP_SUBR_RETURN:       r = '{12, 2, 2, 0, 1, -2, 0, 1};
      OP_LOW_POWER_HALT:    r = '{25, 0, 3, 1, 3, -2, 0, 0};
      OP_BREAKPOINT_ACK:    r = '{14, 1, 0, 0, 0, 0, 0, 0};
      OP_COND_TRAP:         r = '{38, 2, 2, 6, 2, -2, 0, 0};
      OP_FAULT_EXC:         r = '{48, 2, 2, 12, 0, -2, 0, 0};
      OP_RET_FOUR:          r = '{24, 4, 2, 0, 1, -2, 0, 0};
      OP_RET_SIX:           r = '{26, 4, 2, 0, 1, -2, 0, 0};
      default:              r = '{2, 0, 1, 0, 0, 0, 0, 1};
    endcase
    return r;
  endfunction : exp_row

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %0d, seen %0d", what, exp, got);
    end
  endtask : check

  // ==========================================================
  // one operation: start at a falling edge, run to done, compare every result
  // poke raises a refused start mid-run; jitter drops the clock enable at random
  task automatic run_op(input op_t op, input int ea, input bit lng, input int x, input bit wf,
                        input bit poke, input bit jitter);
    row_t r;
    int   t, tl, erd, ewr, busy_n, n, rd0, pf0, wr0;
    r = exp_row(op);
    t = r[0] + 3 * r[6] + ea + ((lng && r[7] == 1) ? 2 : 0);
    tl = r[5] + ((lng && r[7] == 1) ? 2 : 0);
    erd = (op == OP_BOUNDS_PAIR_CHECK) ? x : r[1];
    ewr = (op == OP_RET_FAULT_INSTR) ? int'(wf) : r[3];
    // a pulse on view is not yet counted by the partner, so fold it in
    rd0 = rd_count + int'(o_rd);
    pf0 = pf_count + int'(o_pf);
    wr0 = wr_count + int'(o_wr);
    i_op = op;
    i_ea_clocks = 8'(ea);
    i_long_bus = lng;
    i_operand_reads = 4'(x);
    i_write_fault = wf;
    i_start = 1'b1;
    busy_n = 0;
    n = 0;
    @(negedge i_clk);
    i_start = 1'b0;
    while (o_done !== 1'b1 && n < 400) begin
      // i_ce still holds the value the last rising edge saw
      if (i_ce && o_busy === 1'b1) busy_n++;
      n++;
      i_start = poke && n == 3;
      i_op = (poke && n == 3) ? OP_FAULT_INSTR : op;
      i_ce = jitter ? 1'($urandom_range(0, 1)) : 1'b1;
      @(negedge i_clk);
    end
    i_ce = 1'b1;
    check("elapsed", 16'(t), 16'(o_elapsed));
    check("busy cycles", 16'(t), 16'(busy_n));
    check("reads", 16'(erd), 16'(o_reads));
    check("prefetches", 16'(r[2] + r[6]), 16'(o_prefetches));
    check("writes", 16'(ewr), 16'(o_writes));
    check("bus reads", 16'(erd), 16'(rd_count + int'(o_rd) - rd0));
    check("bus prefetches", 16'(r[2] + r[6]), 16'(pf_count + int'(o_pf) - pf0));
    check("bus writes", 16'(ewr), 16'(wr_count + int'(o_wr) - wr0));
    check("head", 16'(r[4]), 16'(o_head));
    check("tail", 16'(tl), 16'(o_tail));
    check("early next", 16'(tl < 0), 16'(o_early_next));
    check("phase", 16'(PH_IDLE), 16'(o_phase));
  endtask : run_op

  task automatic results();
    $display("comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : results

  // ==========================================================
  // main sequence; every operation starts in the done cycle of the one before
  initial begin
    i_rst_b = 1'b0;
    i_ce = 1'b1;
    i_start = 1'b0;
    i_op = OP_NOP;
    i_long_bus = 1'b0;
    i_ea_clocks = 8'h00;
    i_operand_reads = 4'h0;
    i_write_fault = 1'b0;
    err_count = 0;
    cmp_count = 0;
    void'($urandom(14));
    // rising edges only: the clock's first step from unknown to low must not count as a cycle
    repeat (2) @(posedge i_clk);
    @(negedge i_clk);
    i_rst_b = 1'b1;
    run_op(OP_NOP, 0, 1, 0, 0, 0, 0);
    run_op(OP_SUBR_CALL, 0, 0, 0, 0, 0, 0);
    run_op(OP_SUBR_CALL, 0, 1, 0, 0, 0, 0);
    run_op(OP_BOUNDS_PAIR_CHECK, 2, 0, 1, 0, 0, 0);
    run_op(OP_BOUNDS_PAIR_CHECK, $urandom_range(0, 15), 1, 15, 0, 0, 0);
    run_op(OP_INTERRUPT, 0, 1, 0, 0, 1, 0);
    run_op(OP_FLINE_SECOND_MEM, $urandom_range(1, 15), 0, 0, 0, 0, 0);
    run_op(OP_FLINE_SECOND_REG, 0, 0, 0, 0, 0, 0);
    run_op(OP_FLINE_FIRST, 0, 0, 0, 0, 0, 0);
    run_op(OP_RET_FAULT_INSTR, 0, 0, 0, 0, 0, 0);
    run_op(OP_RET_FAULT_INSTR, 0, 0, 0, 1, 0, 0);
    run_op(OP_RET_FAULT_FOUR, 0, 0, 0, 0, 0, 0);
    run_op(OP_RET_FAULT_SIX, 0, 0, 0, 0, 0, 1);
    run_op(OP_FAULT_INSTR, 0, 0, 0, 0, 1, 0);
    run_op(OP_BIT_MOD_IMM_REG, 0, 0, 0, 0, 0, 0);
    run_op(OP_BIT_MOD_IMM_REG, 4, 0, 0, 0, 0, 0);
    run_op(OP_BIT_TEST_IMM_MEM, $urandom_range(0, 15), 0, 0, 0, 0, 0);
    run_op(OP_BRANCH_TAKEN, 0, 1, 0, 0, 0, 0);
    run_op(OP_DEC_BRANCH_TRUE, 0, 0, 0, 0, 0, 0);
    // random address time, bus width, read count and enable gaps over a mixed set
    foreach (sweep[k]) begin
      run_op(sweep[k], $urandom_range(0, 15), 1'($urandom_range(0, 1)), $urandom_range(0, 15),
             1'($urandom_range(0, 1)), 0, 1);
    end
    @(negedge i_clk);
    check("slot clash", 16'h0000, 16'(clash));
    results();
  end
endmodule : tb_instruction_cycle_timing
